/* design/fmo_consts.vh */
// register offsets, field positions, reset values and timing counts of the field monitor output block
// assumes a 25 MHz core clock and an avalon-mm slave with 32-bit data and byte addressing
// What this block does
// - several instances on one output combine by per-output AND or OR
// - physical outputs default to active high, independent of instance negation
// - output clears immediately by default, or after a hold delay up to ten seconds
// - input-based reset keeps output set until assigned input reaches configured level
// - at most two external switching inputs, delivered by a CAN module
// - switching inputs enable or disable instances by a configured input combination
// - at most ten external switching outputs over at most two CAN modules
// - every CAN node address lies within one to 127
// - sensor CAN node address is one unless reconfigured
// - CAN link runs at fixed 500 kbit/s, modules must match
// - output asserts on field intrusion or contour violation per instance strategy
// - up to sixteen instances, all evaluated concurrently
// - negation inverts an instance result before linking
// - violation reported only after persisting for the instance response time
`ifndef FMO_CONSTS_VH
`define FMO_CONSTS_VH

`define FMO_N_INST        16
`define FMO_N_OUT         10
`define FMO_N_IN          2

// byte offsets
`define FMO_OFS_INST_BASE 8'h00
`define FMO_OFS_LINK      8'h40
`define FMO_OFS_POL       8'h44
`define FMO_OFS_RSTMODE   8'h48
`define FMO_OFS_RSTIN     8'h4C
`define FMO_OFS_HOLD      8'h50
`define FMO_OFS_NODE      8'h54
`define FMO_OFS_OUTS      8'h58
`define FMO_OFS_INS       8'h5C
`define FMO_OFS_STATUS    8'h60
`define FMO_OFS_MASK      8'h64
`define FMO_OFS_BITRATE   8'h68

// per-instance config word fields
`define FMO_IC_EN         0
`define FMO_IC_NEG        1
`define FMO_IC_STRAT      2
`define FMO_IC_OUT_LSB    4
`define FMO_IC_IN_USE_LSB 8
`define FMO_IC_IN_LVL_LSB 10
`define FMO_IC_RESP_LSB   16

// reset mode per output: 2 bits
`define FMO_RM_IMMED      2'h0
`define FMO_RM_DELAY      2'h1
`define FMO_RM_INPUT      2'h2

// reset values
`define FMO_POL_RST       10'h000
`define FMO_NODE_RST      7'h01
`define FMO_NODE_MAX      7'h7F

// timing: hold granularity 1 ms, at most 10 s
`define FMO_CLK_HZ        25000000
`define FMO_TICK_US       1000
`define FMO_TICK_CYC      ((`FMO_CLK_HZ / 1000000) * `FMO_TICK_US)
`define FMO_HOLD_MAX_MS   10000
`define FMO_CAN_KBPS      500
`define FMO_CAN_BIT_CYC   ((`FMO_CLK_HZ / 1000) / `FMO_CAN_KBPS)

`endif

/* design/fmo_tick.v */
// divider giving one-cycle enable pulses at a fixed period
// assumes one core clock and a synchronous active-high reset
`timescale 1ns/1ps
module fmo_tick #(
  parameter DIV = 25000
) (
  // clock and reset
  input  wire core_clk_i,
  input  wire reset_i,
  // enable pulse
  output reg  tick_o
);
  reg [15:0] cnt_reg;

  always @(posedge core_clk_i) begin
    if (reset_i) begin
      cnt_reg <= 16'h0000;
      tick_o  <= 1'b0;
    end else if (cnt_reg == DIV[15:0] - 16'h0001) begin
      cnt_reg <= 16'h0000;
      tick_o  <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
      tick_o  <= 1'b0;
    end
  end
endmodule

/* design/fmo_inst.v */
// one evaluation instance: enable by inputs, response-time filter, negation
// assumes raw violation levels already synchronised and a 1 ms tick
`timescale 1ns/1ps
`include "fmo_consts.vh"
module fmo_inst (
  // clock and reset
  input  wire        core_clk_i,
  input  wire        reset_i,
  input  wire        tick_i,
  // configuration
  input  wire [31:0] cfg_i,
  input  wire [1:0]  sw_in_i,
  // raw results
  input  wire        field_viol_i,
  input  wire        contour_viol_i,
  // filtered result
  output reg         active_o,
  output reg         result_o
);
  reg  [15:0] pers_reg;
  wire        viol;
  wire        gate_ok;
  wire [1:0]  use_m;
  wire [1:0]  lvl_m;
  wire [15:0] resp;

  assign use_m = cfg_i[`FMO_IC_IN_USE_LSB+1:`FMO_IC_IN_USE_LSB];
  assign lvl_m = cfg_i[`FMO_IC_IN_LVL_LSB+1:`FMO_IC_IN_LVL_LSB];
  assign resp  = cfg_i[`FMO_IC_RESP_LSB+15:`FMO_IC_RESP_LSB];
  assign viol  = cfg_i[`FMO_IC_STRAT] ? contour_viol_i : field_viol_i;
  assign gate_ok = cfg_i[`FMO_IC_EN] & (((sw_in_i ~^ lvl_m) | ~use_m) == 2'h3);

  always @(posedge core_clk_i) begin
    if (reset_i) begin
      pers_reg <= 16'h0000;
      active_o <= 1'b0;
      result_o <= 1'b0;
    end else begin
      active_o <= gate_ok;
      if (!gate_ok || !viol) begin
        pers_reg <= 16'h0000;
      end else if (tick_i && pers_reg != 16'hFFFF) begin
        pers_reg <= pers_reg + 16'h0001;
      end
      result_o <= gate_ok & ((viol & (pers_reg >= resp)) ^ cfg_i[`FMO_IC_NEG]);
    end
  end
endmodule

/* design/fmo_top.v */
// field monitor output logic: instances, per-output linking, reset modes, registers
// assumes synchronous violation inputs from the scan engine and async CAN-side inputs
`timescale 1ns/1ps
`include "fmo_consts.vh"
module fmo_top (
  // clock and reset
  input  wire        core_clk_i,
  input  wire        reset_i,
  // avalon-mm slave
  input  wire [7:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output reg  [31:0] avs_readdata_o,
  output wire        avs_waitrequest_o,
  // evaluation results from scan engine
  input  wire [15:0] field_viol_i,
  input  wire [15:0] contour_viol_i,
  // switching inputs from CAN module
  input  wire [1:0]  sw_in_i,
  // switching outputs to CAN modules
  output reg  [9:0]  sw_out_o,
  output reg  [6:0]  can_node_o,
  // interrupt
  output wire        irq_o
);
  localparam NI = `FMO_N_INST;
  localparam NO = `FMO_N_OUT;
  localparam [15:0] HOLD_CAP = `FMO_HOLD_MAX_MS;

  reg  [31:0] icfg_reg [0:NI-1];
  reg  [NO-1:0] link_reg;
  reg  [NO-1:0] pol_reg;
  reg  [2*NO-1:0] rmode_reg;
  reg  [2*NO-1:0] rin_reg;
  reg  [15:0] hold_reg;
  reg  [6:0]  node_reg;
  reg  [NO-1:0] status_reg;
  reg  [NO-1:0] mask_reg;
  reg  [NO-1:0] lout_reg;
  reg  [1:0]  sin_s1_reg;
  reg  [1:0]  sin_s2_reg;
  reg         ack_reg;

  wire        tick;
  wire [NI-1:0] act;
  wire [NI-1:0] res;
  wire [NO-1:0] linked;
  wire [NO-1:0] lout_next;
  wire [NO-1:0] rise;
  wire        acc;
  wire [31:0] wmask;
  wire [15:0] hold_eff;
  wire        wr_en;
  wire        rd_en;
  wire        wr_icfg;
  wire        wr_link;
  wire        wr_pol;
  wire        wr_rmode;
  wire        wr_rin;
  wire        wr_hold;
  wire        wr_node;
  wire        wr_stat;
  wire        wr_mask;
  wire [31:0] m_icfg;
  wire [NO-1:0] m_link;
  wire [NO-1:0] m_pol;
  wire [2*NO-1:0] m_rmode;
  wire [2*NO-1:0] m_rin;
  wire [15:0] m_hold;
  wire [NO-1:0] m_mask;
  wire [NO-1:0] clr_stat;
  reg  [31:0] rd_next;

  function [3:0] out_sel;
    input [31:0] c;
    begin
      out_sel = c[`FMO_IC_OUT_LSB+3:`FMO_IC_OUT_LSB];
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [31:0] m;
    begin
      merge = (old & ~m) | (wd & m);
    end
  endfunction

  // address decode shared by all register strobes except wr_icfg
  function ofs_hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      ofs_hit = (a == ofs);
    end
  endfunction

  fmo_tick #(.DIV(`FMO_TICK_CYC)) u_tick (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .tick_o     (tick)
  );

  // two-flop sync of CAN inputs
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      sin_s1_reg <= 2'h0;
      sin_s2_reg <= 2'h0;
    end else begin
      sin_s1_reg <= sw_in_i;
      sin_s2_reg <= sin_s1_reg;
    end
  end

  // all instances concurrently
  genvar gi;
  generate
    for (gi = 0; gi < NI; gi = gi + 1) begin : g_inst
      fmo_inst u_inst (
        .core_clk_i     (core_clk_i),
        .reset_i        (reset_i),
        .tick_i         (tick),
        .cfg_i          (icfg_reg[gi]),
        .sw_in_i        (sin_s2_reg),
        .field_viol_i   (field_viol_i[gi]),
        .contour_viol_i (contour_viol_i[gi]),
        .active_o       (act[gi]),
        .result_o       (res[gi])
      );
    end
  endgenerate

  // per-output linking, reset modes, hold counter
  genvar go;
  generate
    for (go = 0; go < NO; go = go + 1) begin : g_out
      wire [NI-1:0] hit;
      wire          any;
      wire          in_lvl;
      reg           nx;
      reg  [15:0]   hcnt_reg;
      genvar k;
      for (k = 0; k < NI; k = k + 1) begin : g_hit
        assign hit[k] = act[k] & (out_sel(icfg_reg[k]) == go);
      end
      assign any = |hit;
      assign linked[go] = any & (link_reg[go] ? ((res | ~hit) == {NI{1'b1}})
                                              : |(res & hit));
      assign in_lvl = sin_s2_reg[rin_reg[2*go]] == rin_reg[2*go+1];
      always @* begin
        case (rmode_reg[2*go+1:2*go])
          `FMO_RM_DELAY: nx = linked[go] | (lout_reg[go] & (hcnt_reg != 16'h0000));
          `FMO_RM_INPUT: nx = linked[go] | (lout_reg[go] & ~in_lvl);
          default:       nx = linked[go];
        endcase
      end
      assign lout_next[go] = nx;
      always @(posedge core_clk_i) begin
        if (reset_i) begin
          hcnt_reg <= 16'h0000;
        end else if (linked[go]) begin
          hcnt_reg <= hold_eff;
        end else if (tick && hcnt_reg != 16'h0000) begin
          hcnt_reg <= hcnt_reg - 16'h0001;
        end
      end
    end
  endgenerate

  assign rise = lout_next & ~lout_reg;

  // hold reload value, capped at the ten-second limit
  assign hold_eff = (hold_reg > HOLD_CAP) ? HOLD_CAP : hold_reg;

  // output stage and node address
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      lout_reg   <= {NO{1'b0}};
      sw_out_o   <= 10'h000;
      can_node_o <= `FMO_NODE_RST;
    end else begin
      lout_reg   <= lout_next;
      sw_out_o   <= lout_next ^ pol_reg;
      can_node_o <= node_reg;
    end
  end

  // bus slave: one wait cycle on every access
  assign acc = (avs_read_i | avs_write_i) & ~ack_reg;
  assign avs_waitrequest_o = acc;
  assign wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                  {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign irq_o = |(status_reg & mask_reg);

  // one strobe per register, all in the first request cycle
  assign wr_en    = acc & avs_write_i;
  assign rd_en    = acc & avs_read_i;
  assign wr_icfg  = wr_en & (avs_address_i < `FMO_OFS_LINK);
  assign wr_link  = wr_en & ofs_hit(avs_address_i, `FMO_OFS_LINK);
  assign wr_pol   = wr_en & ofs_hit(avs_address_i, `FMO_OFS_POL);
  assign wr_rmode = wr_en & ofs_hit(avs_address_i, `FMO_OFS_RSTMODE);
  assign wr_rin   = wr_en & ofs_hit(avs_address_i, `FMO_OFS_RSTIN);
  assign wr_hold  = wr_en & ofs_hit(avs_address_i, `FMO_OFS_HOLD);
  assign wr_node  = wr_en & ofs_hit(avs_address_i, `FMO_OFS_NODE) & avs_byteenable_i[0];
  assign wr_stat  = wr_en & ofs_hit(avs_address_i, `FMO_OFS_STATUS);
  assign wr_mask  = wr_en & ofs_hit(avs_address_i, `FMO_OFS_MASK);

  // byte-lane merge, cut to each register's width
  assign m_icfg  = merge(icfg_reg[avs_address_i[5:2]], avs_writedata_i, wmask);
  assign m_link  = (link_reg & ~wmask[NO-1:0]) | (avs_writedata_i[NO-1:0] & wmask[NO-1:0]);
  assign m_pol   = (pol_reg & ~wmask[NO-1:0]) | (avs_writedata_i[NO-1:0] & wmask[NO-1:0]);
  assign m_rmode = (rmode_reg & ~wmask[2*NO-1:0])
                 | (avs_writedata_i[2*NO-1:0] & wmask[2*NO-1:0]);
  assign m_rin   = (rin_reg & ~wmask[2*NO-1:0])
                 | (avs_writedata_i[2*NO-1:0] & wmask[2*NO-1:0]);
  assign m_hold  = (hold_reg & ~wmask[15:0]) | (avs_writedata_i[15:0] & wmask[15:0]);
  assign m_mask  = (mask_reg & ~wmask[NO-1:0]) | (avs_writedata_i[NO-1:0] & wmask[NO-1:0]);
  assign clr_stat = wr_stat ? (avs_writedata_i[NO-1:0] & wmask[NO-1:0]) : {NO{1'b0}};

  // read mux
  always @* begin
    rd_next = 32'h00000000;
    if (avs_address_i < `FMO_OFS_LINK) begin
      rd_next = icfg_reg[avs_address_i[5:2]];
    end else begin
      case (avs_address_i)
        `FMO_OFS_LINK:    rd_next = {22'h0, link_reg};
        `FMO_OFS_POL:     rd_next = {22'h0, pol_reg};
        `FMO_OFS_RSTMODE: rd_next = {12'h0, rmode_reg};
        `FMO_OFS_RSTIN:   rd_next = {12'h0, rin_reg};
        `FMO_OFS_HOLD:    rd_next = {16'h0, hold_reg};
        `FMO_OFS_NODE:    rd_next = {25'h0, node_reg};
        `FMO_OFS_OUTS:    rd_next = {22'h0, lout_reg};
        `FMO_OFS_INS:     rd_next = {30'h0, sin_s2_reg};
        `FMO_OFS_STATUS:  rd_next = {22'h0, status_reg};
        `FMO_OFS_MASK:    rd_next = {22'h0, mask_reg};
        `FMO_OFS_BITRATE: rd_next = `FMO_CAN_KBPS;
        default:          rd_next = 32'h00000000;
      endcase
    end
  end

  integer i;
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      ack_reg    <= 1'b0;
      link_reg   <= {NO{1'b0}};
      pol_reg    <= `FMO_POL_RST;
      rmode_reg  <= {2*NO{1'b0}};
      rin_reg    <= {2*NO{1'b0}};
      hold_reg   <= 16'h0000;
      node_reg   <= `FMO_NODE_RST;
      mask_reg   <= {NO{1'b0}};
      for (i = 0; i < NI; i = i + 1) begin
        icfg_reg[i] <= 32'h00000000;
      end
    end else begin
      ack_reg <= acc;
      if (wr_icfg) begin
        icfg_reg[avs_address_i[5:2]] <= m_icfg;
      end
      if (wr_link) begin
        link_reg <= m_link;
      end
      if (wr_pol) begin
        pol_reg <= m_pol;
      end
      if (wr_rmode) begin
        rmode_reg <= m_rmode;
      end
      if (wr_rin) begin
        rin_reg <= m_rin;
      end
      if (wr_hold) begin
        hold_reg <= m_hold;
      end
      if (wr_node && avs_writedata_i[6:0] != 7'h00) begin
        node_reg <= avs_writedata_i[6:0];
      end
      if (wr_mask) begin
        mask_reg <= m_mask;
      end
    end
  end

  // sticky status: a rising output beats a clear in the same cycle
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      status_reg     <= {NO{1'b0}};
      avs_readdata_o <= 32'h00000000;
    end else begin
      status_reg <= (status_reg & ~clr_stat) | rise;
      if (rd_en) begin
        avs_readdata_o <= rd_next;
      end
    end
  end
endmodule

/* verif/fmo_top_props.sv */
// assertions on the port relations of fmo_top
// assumes binding into fmo_top, one clock, sync reset
`timescale 1ns/1ps
module fmo_top_props (
  // clock and reset
  input wire        core_clk_i,
  input wire        reset_i,
  // bus
  input wire [7:0]  avs_address_i,
  input wire        avs_read_i,
  input wire        avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0]  avs_byteenable_i,
  input wire [31:0] avs_readdata_o,
  input wire        avs_waitrequest_o,
  // outputs
  input wire [9:0]  sw_out_o,
  input wire [6:0]  can_node_o,
  input wire        irq_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  wire take = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
  wire nwr  = take & avs_write_i & (avs_address_i == 8'h54) & avs_byteenable_i[0];
  property p_node_rst; reset_i |=> can_node_o == 7'h01; endproperty
  a_node_rst: assert property (p_node_rst) else $error("node reset");
  property p_node_rng; disable iff (reset_i) can_node_o != 7'h00; endproperty
  a_node_rng: assert property (p_node_rng) else $error("node zero");
  property p_node_zero;
    disable iff (reset_i) nwr && avs_writedata_i[6:0] == 7'h00 |=> $stable(can_node_o);
  endproperty
  a_node_zero: assert property (p_node_zero) else $error("node took zero");
  property p_node_wr;
    disable iff (reset_i) nwr && avs_writedata_i[6:0] != 7'h00
      |=> can_node_o == $past(avs_writedata_i[6:0]);
  endproperty
  a_node_wr: assert property (p_node_wr) else $error("node write");
  property p_out_rst; reset_i |=> sw_out_o == 10'h000; endproperty
  a_out_rst: assert property (p_out_rst) else $error("out reset");
  property p_rate;
    disable iff (reset_i) take && avs_read_i && avs_address_i == 8'h68
      |-> avs_readdata_o == 32'h000001F4;
  endproperty
  a_rate: assert property (p_rate) else $error("bit rate");
  property p_ins;
    disable iff (reset_i) take && avs_read_i && avs_address_i == 8'h5C
      |-> avs_readdata_o[31:2] == 30'h0;
  endproperty
  a_ins: assert property (p_ins) else $error("input count");
  property p_wait;
    disable iff (reset_i) $rose(avs_read_i | avs_write_i)
      |-> avs_waitrequest_o ##1 !avs_waitrequest_o;
  endproperty
  a_wait: assert property (p_wait) else $error("wait cycle");
  property p_irq_rst; reset_i |=> !irq_o; endproperty
  a_irq_rst: assert property (p_irq_rst) else $error("irq reset");
endmodule

/* verif/fmo_can_io.sv */
// model of the CAN I/O module: switching inputs in, outputs seen
// assumes one core clock, one cycle of link delay
`timescale 1ns/1ps
module fmo_can_io #(
  parameter KBPS = 500
) (
  input  wire       core_clk_i,
  input  wire [1:0] level_i,
  input  wire [9:0] sw_out_i,
  output reg  [1:0] sw_in_o,
  output reg  [9:0] out_seen_o
);
  always @(posedge core_clk_i) begin
    sw_in_o    <= level_i;
    out_seen_o <= sw_out_i;
  end
endmodule

/* verif/field_monitor_output_logic_test.sv */
// self-checking bench of fmo_top with a CAN I/O model
// assumes 25 MHz clock and a 1 ms hold tick
`timescale 1ns/1ps
module field_monitor_output_logic_test;
  reg         core_clk_i;
  reg         reset_i;
  reg  [7:0]  avs_address_i;
  reg         avs_read_i;
  reg         avs_write_i;
  reg  [31:0] avs_writedata_i;
  reg  [3:0]  avs_byteenable_i;
  wire [31:0] avs_readdata_o;
  wire        avs_waitrequest_o;
  reg  [15:0] field_viol_i;
  reg  [15:0] contour_viol_i;
  reg  [1:0]  level_reg;
  wire [1:0]  sw_in_i;
  wire [9:0]  sw_out_o;
  wire [6:0]  can_node_o;
  wire        irq_o;
  wire [9:0]  out_seen;
  integer     err_count;
  integer     comparisons;
  integer     i;
  integer     k;
  reg  [31:0] rdat;
  reg  [31:0] v;
  fmo_top fmo_top_inst (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .field_viol_i(field_viol_i), .contour_viol_i(contour_viol_i), .sw_in_i(sw_in_i),
    .sw_out_o(sw_out_o), .can_node_o(can_node_o), .irq_o(irq_o));
  fmo_can_io fmo_can_io_inst (.core_clk_i(core_clk_i), .level_i(level_reg),
    .sw_out_i(sw_out_o), .sw_in_o(sw_in_i), .out_seen_o(out_seen));
  function [9:0] link_exp(input lk, input a, input b);
    link_exp = {9'h000, lk ? (a & b) : (a | b)};
  endfunction
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("wrong value %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task acc(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge core_clk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= w;
      avs_read_i <= ~w;
      @(posedge core_clk_i);
      while (avs_waitrequest_o) @(posedge core_clk_i);
      rdat = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
    end
  endtask
  task sv(input [15:0] f, input [15:0] c, input [1:0] l);
    begin
      @(posedge core_clk_i);
      field_viol_i <= f;
      contour_viol_i <= c;
      level_reg <= l;
      repeat (6) @(posedge core_clk_i);
    end
  endtask
  task stop_test;
    begin
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) begin
        $display("[ PASS ]");
      end else begin
        $display("[ FAIL ]");
      end
      $finish;
    end
  endtask
  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  initial begin
    #(40 * 90000);
    err_count = err_count + 1;
    stop_test;
  end
  initial begin
    reset_i = 1'b1;
    avs_address_i = 8'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hF;
    field_viol_i = 16'h0;
    contour_viol_i = 16'h0;
    level_reg = 2'h0;
    err_count = 0;
    comparisons = 0;
    v = $urandom(1668);
    repeat (12) @(posedge core_clk_i);
    reset_i <= 1'b0;
    chk("node", 32'h1, can_node_o);
    chk("outs", 32'h0, sw_out_o);
    acc(1'b0, 8'h68, 32'h0);
    chk("rate", 32'h1F4, rdat);
    acc(1'b0, 8'hFC, 32'h0);
    chk("unmapped", 32'h0, rdat);
    acc(1'b1, 8'h54, 32'h0);
    @(posedge core_clk_i);
    chk("node", 32'h1, can_node_o);
    acc(1'b1, 8'h54, 32'h7F);
    @(posedge core_clk_i);
    chk("node", 32'h7F, can_node_o);
    acc(1'b1, 8'h00, 32'h1);
    acc(1'b1, 8'h04, 32'h5);
    for (k = 0; k < 2; k = k + 1) begin
      acc(1'b1, 8'h40, k);
      for (i = 0; i < 16; i = i + 1) begin
        v = $urandom;
        sv(v[15:0], v[31:16], 2'h0);
        chk("link", link_exp(k, v[0], v[17]), sw_out_o);
        chk("seen", link_exp(k, v[0], v[17]), out_seen);
      end
    end
    acc(1'b1, 8'h04, 32'h0);
    acc(1'b1, 8'h00, 32'h3);
    sv(16'h0, 16'h0, 2'h0);
    chk("neg", 32'h1, sw_out_o);
    acc(1'b1, 8'h44, 32'h1);
    sv(16'h1, 16'h0, 2'h0);
    chk("pol", 32'h1, sw_out_o);
    acc(1'b1, 8'h44, 32'h0);
    acc(1'b1, 8'h00, 32'h501);
    sv(16'h1, 16'h0, 2'h0);
    chk("gate", 32'h0, sw_out_o);
    sv(16'h1, 16'h0, 2'h1);
    chk("gate", 32'h1, sw_out_o);
    acc(1'b1, 8'h64, 32'h1);
    acc(1'b1, 8'h60, 32'h3FF);
    chk("irq", 32'h0, irq_o);
    sv(16'h0, 16'h0, 2'h1);
    sv(16'h1, 16'h0, 2'h1);
    chk("irq", 32'h1, irq_o);
    acc(1'b1, 8'h64, 32'h0);
    chk("irq", 32'h0, irq_o);
    acc(1'b1, 8'h64, 32'h1);
    acc(1'b1, 8'h60, 32'h1);
    chk("irq", 32'h0, irq_o);
    acc(1'b1, 8'h00, 32'h1);
    acc(1'b1, 8'h48, 32'h2);
    acc(1'b1, 8'h4C, 32'h2);
    sv(16'h1, 16'h0, 2'h0);
    sv(16'h0, 16'h0, 2'h0);
    chk("inrst", 32'h1, sw_out_o);
    sv(16'h0, 16'h0, 2'h1);
    chk("inrst", 32'h0, sw_out_o);
    acc(1'b1, 8'h48, 32'h1);
    acc(1'b1, 8'h50, 32'h2);
    sv(16'h1, 16'h0, 2'h0);
    sv(16'h0, 16'h0, 2'h0);
    repeat (20000) @(posedge core_clk_i);
    chk("hold", 32'h1, sw_out_o);
    repeat (32000) @(posedge core_clk_i);
    chk("hold", 32'h0, sw_out_o);
    stop_test;
  end
endmodule
bind fmo_top fmo_top_props fmo_top_props_inst (.core_clk_i(core_clk_i), .reset_i(reset_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .sw_out_o(sw_out_o), .can_node_o(can_node_o), .irq_o(irq_o));
